// *** hw/ccp_pkg.sv ***
// Constants and carrier types shared by the core clock and pipeline logic
package ccp_pkg;
   localparam int PC_W     = 13;
   localparam int INSTR_W  = 14;
   localparam int DATA_W   = 8;
   localparam int DADDR_W  = 8;
   localparam int EE_AW    = 6;
   localparam int EE_DEPTH = 64;
   localparam int OSC_DIV  = 4;

   // Oscillator period and the quarter-rate instruction cycle derived from it
   localparam int OSC_PERIOD_NS   = 10;
   localparam int INSTR_CYCLE_NS  = OSC_DIV * OSC_PERIOD_NS;

   localparam logic [PC_W-1:0]    RESET_VEC      = 13'h0000;
   localparam logic [PC_W-1:0]    INT_VEC        = 13'h0004;
   localparam logic [PC_W-1:0]    PC_ONE         = 13'h0001;
   localparam logic [PC_W-1:0]    PROG_IMPL_MASK = 13'h03ff;
   localparam logic [EE_AW-1:0]   EE_LAST        = 6'h3f;
   localparam logic [INSTR_W-1:0] INSTR_RST      = 14'h0000;
   localparam logic [DATA_W-1:0]  DATA_RST       = 8'h00;
   localparam logic [DADDR_W-1:0] DADDR_RST      = 8'h00;
   localparam logic [3:0]         PH_ONEHOT_RST  = 4'h1;

   typedef enum logic [1:0] {
      PH_ONE,
      PH_TWO,
      PH_THREE,
      PH_FOUR
   } ccp_phase_t;

   // Answer of the execute unit for the instruction in the execute stage
   typedef struct packed {
      logic               branch;
      logic [PC_W-1:0]    target;
      logic               write_en;
      logic [DADDR_W-1:0] addr;
      logic [DATA_W-1:0]  result;
   } ccp_exec_t;

   // Data memory bus driven by the core
   typedef struct packed {
      logic               rd;
      logic               wr;
      logic [DADDR_W-1:0] addr;
      logic [DATA_W-1:0]  wdata;
   } ccp_dbus_t;
endpackage

// *** hw/ccp_eeprom.sv ***
// Data EEPROM array reached only through its own address pointer
`timescale 1ns/10ps
module ccp_eeprom
   import ccp_pkg::*;
(
   input  wire logic              clk,      // Oscillator clock
   input  wire logic              rst_n,    // Synchronised reset, low active
   input  wire logic              clr,      // Master clear held
   input  wire logic              ptr_we,   // Load address pointer
   input  wire logic [DATA_W-1:0] ptr_data, // New pointer value
   input  wire logic              wr,       // Write at pointer
   input  wire logic              rd,       // Read at pointer
   input  wire logic [DATA_W-1:0] wdata,    // Write data
   output logic      [DATA_W-1:0] rdata     // Read data register
);
   logic [EE_AW-1:0]  ptr_reg;
   logic [EE_AW-1:0]  ptr_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [DATA_W-1:0] mem_reg  [EE_DEPTH];
   logic [DATA_W-1:0] mem_next [EE_DEPTH];

   // One write port per entry, selected only by the pointer
   genvar i;
   generate
      for (i = 0; i < EE_DEPTH; i++) begin : g_entry
         assign mem_next[i] = (wr && !clr && ptr_reg == EE_AW'(i)) ? wdata : mem_reg[i];
      end
   endgenerate

   // Pointer keeps only 0h-3Fh; upper bits of the written byte fall away
   always_comb begin
      ptr_next   = ptr_reg;
      rdata_next = rdata_reg;
      if (clr) begin
         ptr_next   = '0;
         rdata_next = DATA_RST;
      end else begin
         if (rd) begin
            rdata_next = mem_reg[ptr_reg];
         end
         if (ptr_we) begin
            ptr_next = ptr_data[EE_AW-1:0] & EE_LAST;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_reg   <= '0;
         rdata_reg <= DATA_RST;
      end else begin
         ptr_reg   <= ptr_next;
         rdata_reg <= rdata_next;
      end
   end

   // Contents are non-volatile, so reset leaves them alone
   always_ff @(posedge clk) begin
      mem_reg <= mem_next;
   end

   assign rdata = rdata_reg;

   property p_ee_read;
      @(posedge clk) disable iff (!rst_n)
      (rd && !clr) |=> (rdata_reg == $past(mem_reg[ptr_reg]));
   endproperty
   a_ee_read: assert property (p_ee_read) else $error("eeprom read data wrong");
endmodule

// *** hw/ccp_core.sv ***
// Core phase generator and two-stage fetch/execute pipeline
`timescale 1ns/10ps
module ccp_core
   import ccp_pkg::*;
(
   input  wire logic               CLK,                        // Oscillator input
   input  wire logic               RST_N,                      // Power reset, low
   input  wire logic               MASTER_CLEAR_N,             // Master clear, low
   input  wire logic               RC_MODE,                    // RC oscillator option
   input  wire logic [INSTR_W-1:0] PROG_DATA,                  // Program word
   input  wire logic [DATA_W-1:0]  DATA_RDATA,                 // Data memory read
   input  wire ccp_exec_t          EXEC,                       // Execute unit answer
   input  wire logic               INT_REQ,                    // Interrupt request
   input  wire logic               EE_PTR_WE,                  // Load EEPROM pointer
   input  wire logic [DATA_W-1:0]  EE_PTR_DATA,                // EEPROM pointer value
   input  wire logic               EE_WR,                      // EEPROM write
   input  wire logic               EE_RD,                      // EEPROM read
   input  wire logic [DATA_W-1:0]  EE_WDATA,                   // EEPROM write data
   output logic      [PC_W-1:0]    PROG_ADDR,                  // Program address
   output logic                    PROG_RD,                    // Program read strobe
   output logic      [INSTR_W-1:0] INSTR,                      // Instruction register
   output logic                    EXEC_VALID,                 // Execute stage live
   output logic      [DATA_W-1:0]  OPERAND,                    // Captured operand
   output ccp_dbus_t               DMEM,                       // Data memory bus
   output logic                    INT_ACK,                    // Interrupt entered
   output logic                    PHASE_ONE,                  // Phase one
   output logic                    PHASE_TWO,                  // Phase two
   output logic                    PHASE_THREE,                // Phase three
   output logic                    PHASE_FOUR,                 // Phase four
   output logic                    OSC_OUTPUT_CYCLE_CLOCK_PIN, // Cycle clock out
   output logic      [DATA_W-1:0]  EE_RDATA                    // EEPROM read data
);
   logic rst_meta_reg;
   logic rst_sync_n;
   logic core_clr;

   // Power reset released through two flops; only the second is used
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // Master clear acts as a synchronous hold of all core state
   assign core_clr = !MASTER_CLEAR_N;

   ccp_phase_t   phase_reg;
   ccp_phase_t   phase_next;
   logic [3:0]   ph_reg;
   logic [3:0]   ph_next;
   logic         clkout_reg;
   logic         clkout_next;

   // Divide by four into a ring of phases, parked in phase one under clear
   always_comb begin
      case (phase_reg)
         PH_ONE:   phase_next = PH_TWO;
         PH_TWO:   phase_next = PH_THREE;
         PH_THREE: phase_next = PH_FOUR;
         PH_FOUR:  phase_next = PH_ONE;
         default:  phase_next = PH_ONE;
      endcase
      if (core_clr) begin
         phase_next = PH_ONE;
      end
      ph_next     = 4'h1 << phase_next;
      // High in phases three and four gives a 50 percent quarter-rate clock
      clkout_next = RC_MODE && !core_clr &&
                    (phase_next == PH_THREE || phase_next == PH_FOUR);
   end

   always_ff @(posedge CLK or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase_reg  <= PH_ONE;
         ph_reg     <= PH_ONEHOT_RST;
         clkout_reg <= 1'b0;
      end else begin
         phase_reg  <= phase_next;
         ph_reg     <= ph_next;
         clkout_reg <= clkout_next;
      end
   end

   logic [PC_W-1:0]    pc_reg;
   logic [PC_W-1:0]    pc_next;
   logic [PC_W-1:0]    paddr_reg;
   logic [PC_W-1:0]    paddr_next;
   logic               prd_reg;
   logic               prd_next;
   logic [INSTR_W-1:0] instr_reg;
   logic [INSTR_W-1:0] instr_next;
   logic               valid_reg;
   logic               valid_next;
   logic               iack_reg;
   logic               iack_next;
   logic               branch_take;
   logic               int_take;
   logic [PC_W-1:0]    fetch_addr;

   // Branch wins over a pending interrupt at the same boundary, so its target is fetched first
   assign branch_take = (phase_reg == PH_FOUR) && valid_reg && EXEC.branch;
   assign int_take    = (phase_reg == PH_FOUR) && INT_REQ && !branch_take;

   // Fetch stage: address chosen at the end of phase four, counter steps in phase one
   always_comb begin
      pc_next    = pc_reg;
      paddr_next = paddr_reg;
      prd_next   = prd_reg;
      instr_next = instr_reg;
      valid_next = valid_reg;
      iack_next  = 1'b0;
      fetch_addr = pc_reg;
      if (branch_take) begin
         fetch_addr = EXEC.target;
      end else if (int_take) begin
         fetch_addr = INT_VEC;
      end
      if (core_clr) begin
         pc_next    = RESET_VEC;
         paddr_next = RESET_VEC;
         prd_next   = 1'b0;
         instr_next = INSTR_RST;
         valid_next = 1'b0;
      end else begin
         case (phase_reg)
            PH_ONE: begin
               pc_next = PC_W'(pc_reg + PC_ONE);
            end
            PH_THREE: begin
               prd_next = 1'b1;
            end
            PH_FOUR: begin
               prd_next   = 1'b0;
               instr_next = PROG_DATA;
               // A redirect flushes the word just fetched
               valid_next = !(branch_take || int_take);
               pc_next    = fetch_addr;
               paddr_next = fetch_addr & PROG_IMPL_MASK;
               iack_next  = int_take;
            end
            default: begin
               prd_next = prd_reg;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pc_reg    <= RESET_VEC;
         paddr_reg <= RESET_VEC;
         prd_reg   <= 1'b0;
         instr_reg <= INSTR_RST;
         valid_reg <= 1'b0;
         iack_reg  <= 1'b0;
      end else begin
         pc_reg    <= pc_next;
         paddr_reg <= paddr_next;
         prd_reg   <= prd_next;
         instr_reg <= instr_next;
         valid_reg <= valid_next;
         iack_reg  <= iack_next;
      end
   end

   ccp_dbus_t         dbus_reg;
   ccp_dbus_t         dbus_next;
   logic [DATA_W-1:0] opnd_reg;
   logic [DATA_W-1:0] opnd_next;

   // Data bus runs apart from the program bus; read in phase two, write in four
   always_comb begin
      dbus_next = dbus_reg;
      opnd_next = opnd_reg;
      if (core_clr) begin
         dbus_next = '0;
         opnd_next = DATA_RST;
      end else begin
         case (phase_reg)
            PH_ONE: begin
               dbus_next.rd   = valid_reg;
               dbus_next.addr = EXEC.addr;
            end
            PH_TWO: begin
               dbus_next.rd = 1'b0;
               if (dbus_reg.rd) begin
                  opnd_next = DATA_RDATA;
               end
            end
            PH_THREE: begin
               dbus_next.wr    = valid_reg && EXEC.write_en;
               dbus_next.addr  = EXEC.addr;
               dbus_next.wdata = EXEC.result;
            end
            PH_FOUR: begin
               dbus_next.wr = 1'b0;
            end
            default: begin
               dbus_next = dbus_reg;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dbus_reg <= '0;
         opnd_reg <= DATA_RST;
      end else begin
         dbus_reg <= dbus_next;
         opnd_reg <= opnd_next;
      end
   end

   // EEPROM sits beside data memory, reached through its pointer only
   ccp_eeprom u_eeprom (
      .clk      (CLK),
      .rst_n    (rst_sync_n),
      .clr      (core_clr),
      .ptr_we   (EE_PTR_WE),
      .ptr_data (EE_PTR_DATA),
      .wr       (EE_WR),
      .rd       (EE_RD),
      .wdata    (EE_WDATA),
      .rdata    (EE_RDATA)
   );

   // Outputs straight from their flops
   assign PROG_ADDR                  = paddr_reg;
   assign PROG_RD                    = prd_reg;
   assign INSTR                      = instr_reg;
   assign EXEC_VALID                 = valid_reg;
   assign OPERAND                    = opnd_reg;
   assign DMEM                       = dbus_reg;
   assign INT_ACK                    = iack_reg;
   assign PHASE_ONE                  = ph_reg[0];
   assign PHASE_TWO                  = ph_reg[1];
   assign PHASE_THREE                = ph_reg[2];
   assign PHASE_FOUR                 = ph_reg[3];
   assign OSC_OUTPUT_CYCLE_CLOCK_PIN = clkout_reg;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_sync_n || core_clr);

   // Sampled guards, as disable iff already sees a release at its own edge
   property p_phase_ring;
      (PHASE_ONE && MASTER_CLEAR_N && rst_sync_n)
         |=> PHASE_TWO ##1 PHASE_THREE ##1 PHASE_FOUR ##1 PHASE_ONE;
   endproperty
   a_phase_ring: assert property (p_phase_ring) else $error("phase ring broken");

   property p_phase_onehot;
      $onehot(ph_reg) && (ph_reg == (4'h1 << phase_reg));
   endproperty
   a_phase_onehot: assert property (p_phase_onehot) else $error("phases overlap");

   property p_pc_step;
      (PHASE_ONE && MASTER_CLEAR_N && rst_sync_n)
         |=> (pc_reg == PC_W'($past(pc_reg) + PC_ONE));
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step in phase one");

   property p_capture;
      (PHASE_FOUR && MASTER_CLEAR_N) |=> (INSTR == $past(PROG_DATA)) && PROG_ADDR[0] == pc_reg[0];
   endproperty
   a_capture: assert property (p_capture) else $error("fetch word not captured");

   property p_exec_start;
      $rose(EXEC_VALID) |-> $past(PHASE_FOUR);
   endproperty
   a_exec_start: assert property (p_exec_start) else $error("execute started off boundary");

   property p_flow;
      (branch_take == 1'b0 && int_take == 1'b0 && PHASE_FOUR && EXEC_VALID && MASTER_CLEAR_N)
         |=> EXEC_VALID [*4];
   endproperty
   a_flow: assert property (p_flow) else $error("plain instruction stalled");

   property p_branch_two;
      // A deferred interrupt may take the flush cycle's boundary instead
      (branch_take && MASTER_CLEAR_N) |=> !EXEC_VALID [*4]
         ##1 (EXEC_VALID || INT_ACK || !MASTER_CLEAR_N);
   endproperty
   a_branch_two: assert property (p_branch_two) else $error("branch not two cycles");

   property p_branch_target;
      (branch_take && MASTER_CLEAR_N) |=> (PROG_ADDR == ($past(EXEC.target) & PROG_IMPL_MASK));
   endproperty
   a_branch_target: assert property (p_branch_target) else $error("target not fetched");

   property p_data_phase;
      (DMEM.rd |-> PHASE_TWO) and (DMEM.wr |-> (PHASE_FOUR && EXEC_VALID));
   endproperty
   a_data_phase: assert property (p_data_phase) else $error("data access in wrong phase");

   property p_cycle_clock;
      (RC_MODE && PHASE_TWO) |=> OSC_OUTPUT_CYCLE_CLOCK_PIN ##1 OSC_OUTPUT_CYCLE_CLOCK_PIN;
   endproperty
   a_cycle_clock: assert property (p_cycle_clock) else $error("cycle clock wrong");

   property p_clear;
      @(posedge CLK) disable iff (!rst_sync_n)
      !MASTER_CLEAR_N |=> (pc_reg == RESET_VEC) && !EXEC_VALID && PHASE_ONE && !DMEM.wr;
   endproperty
   a_clear: assert property (p_clear) else $error("master clear not held");

   property p_int_vec;
      (int_take && MASTER_CLEAR_N) |=> (PROG_ADDR == INT_VEC) && INT_ACK;
   endproperty
   a_int_vec: assert property (p_int_vec) else $error("interrupt vector wrong");

   property p_wrap;
      (PROG_ADDR & ~PROG_IMPL_MASK) == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address beyond implemented memory");
endmodule

// *** testbench/ccp_mem_model.sv ***
// Program memory, data memory and toy execute decode facing the core
`timescale 1ns/10ps
module ccp_mem_model
   import ccp_pkg::*;
(
   input  wire logic               clk,        // Oscillator clock
   input  wire logic [PC_W-1:0]    prog_addr,  // Fetch address
   input  wire logic               prog_rd,    // Fetch strobe
   output logic      [INSTR_W-1:0] prog_data,  // Program word
   input  wire ccp_dbus_t          dmem,       // Data bus
   output logic      [DATA_W-1:0]  data_rdata, // Data read
   input  wire logic [INSTR_W-1:0] instr,      // Word in execute
   input  wire logic [DATA_W-1:0]  operand,    // Captured operand
   output ccp_exec_t               exec        // Decoded answer
);
   logic [INSTR_W-1:0] pmem [1024];
   logic [DATA_W-1:0]  dram [256];

   // Outside the strobe the buses show inverted data, so stale words never pass
   assign prog_data  = prog_rd ? pmem[prog_addr[9:0]] : ~pmem[prog_addr[9:0]];
   assign data_rdata = dmem.rd ? dram[dmem.addr] : ~dram[dmem.addr];

   // Data write on the strobe, independent of the program bus
   always @(posedge clk) begin
      if (dmem.wr) begin
         dram[dmem.addr] <= dmem.wdata;
      end
   end

   // Bit 13 branches to the low bits, otherwise bit 12 writes back operand plus one
   always_comb begin
      exec.branch   = instr[13];
      exec.target   = instr[12:0];
      exec.write_en = ~instr[13] & instr[12];
      exec.addr     = instr[7:0];
      exec.result   = operand + 8'h01;
   end
endmodule

// *** testbench/test_core_clock_phase_pipeline.sv ***
// Self-checking bench for the core phase generator and pipeline
`timescale 1ns/10ps
module test_core_clock_phase_pipeline;
   import ccp_pkg::*;
   typedef struct packed {
      logic [13:0] word;
      logic [7:0]  init;
      logic        wr;
      logic [7:0]  wdata;
   } ccp_row_t;

   logic               clk, rst_n, master_clear_n_n, rc_mode, int_req, ee_ptr_we, ee_wr, ee_rd;
   logic [7:0]         ee_ptr_data, ee_wdata, data_rdata, operand, ee_rdata;
   logic [PC_W-1:0]    prog_addr;
   logic [INSTR_W-1:0] prog_data, instr;
   logic               prog_rd, exec_valid, int_ack, p1, p2, p3, p4, clk_out;
   ccp_dbus_t          dmem;
   ccp_exec_t          exec;
   ccp_row_t           rows [4];
   int                 num_errors = 0;
   int                 tests_run = 0;
   int                 k;

   ccp_core dut (.CLK(clk), .RST_N(rst_n), .MASTER_CLEAR_N(master_clear_n_n), .RC_MODE(rc_mode),
      .PROG_DATA(prog_data), .DATA_RDATA(data_rdata), .EXEC(exec), .INT_REQ(int_req),
      .EE_PTR_WE(ee_ptr_we), .EE_PTR_DATA(ee_ptr_data), .EE_WR(ee_wr), .EE_RD(ee_rd),
      .EE_WDATA(ee_wdata), .PROG_ADDR(prog_addr), .PROG_RD(prog_rd), .INSTR(instr),
      .EXEC_VALID(exec_valid), .OPERAND(operand), .DMEM(dmem), .INT_ACK(int_ack),
      .PHASE_ONE(p1), .PHASE_TWO(p2), .PHASE_THREE(p3), .PHASE_FOUR(p4),
      .OSC_OUTPUT_CYCLE_CLOCK_PIN(clk_out), .EE_RDATA(ee_rdata));

   ccp_mem_model mdl (.clk(clk), .prog_addr(prog_addr), .prog_rd(prog_rd),
      .prog_data(prog_data), .dmem(dmem), .data_rdata(data_rdata), .instr(instr),
      .operand(operand), .exec(exec));

   // 100 MHz oscillator
   always #5 clk = ~clk;

   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // Outputs are sampled mid-cycle, clear of the launching edge
   task automatic step();
      @(negedge clk);
   endtask

   // Step into phase n (0 is phase one) and check phases and cycle clock
   task automatic ph(int n);
      step();
      check("phases", {p1, p2, p3, p4}, 4'b1000 >> n);
      check("clk_out", clk_out, rc_mode && n >= 2);
   endtask

   // Bounded search for the next phase one
   task automatic sync1();
      step();
      for (k = 0; k < 8 && p1 !== 1'b1; k++) step();
      check("phase_one", p1, 1'b1);
   endtask

   // Bounded search for phase two of the first cycle after a release
   task automatic first_cycle();
      for (k = 0; k < 8 && p2 !== 1'b1; k++) step();
      check("first_idle", {exec_valid, dmem.rd, dmem.wr, prog_addr}, 0);
   endtask

   // One EEPROM access, inputs held for one edge
   task automatic ee(logic we, logic rd, logic wr, logic [7:0] pd, logic [7:0] wd);
      @(posedge clk);
      {ee_ptr_we, ee_rd, ee_wr, ee_ptr_data, ee_wdata} <= {we, rd, wr, pd, wd};
      @(posedge clk);
      {ee_ptr_we, ee_rd, ee_wr} <= 3'h0;
      step();
   endtask

   // Hang guard, well beyond the fewer than a hundred cycles of the sequence
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      {clk, rst_n, master_clear_n_n, rc_mode, int_req} = 5'b00110;
      {ee_ptr_we, ee_rd, ee_wr, ee_ptr_data, ee_wdata} = '0;
      // Word, data preset, write expected, value written
      rows[0] = '{14'h1000, 8'h00, 1'b1, 8'h01};
      rows[1] = '{14'h10ff, 8'hfe, 1'b1, 8'hff};
      rows[2] = '{14'h005a, 8'h5a, 1'b0, 8'h00};
      rows[3] = '{14'h1010, 8'hff, 1'b1, 8'h00};
      for (int i = 0; i < 1024; i++) mdl.pmem[i] = 14'h0000;
      for (int i = 0; i < 4; i++) begin
         mdl.pmem[i] = rows[i].word;
         mdl.dram[rows[i].word[7:0]] = rows[i].init;
      end
      mdl.pmem[4] = 14'h3020; // Branch whose target wraps to 020
      mdl.pmem[5] = 14'h1044; // Prefetched behind the branch
      mdl.pmem[13'h020] = 14'h1033;
      mdl.pmem[13'h021] = 14'h1034; // Prefetched behind the interrupt
      mdl.dram[8'h33] = 8'h32;
      mdl.dram[8'h34] = 8'h34;
      mdl.dram[8'h44] = 8'h44;
      repeat (4) step();
      check("reset", {p1, p2, p3, p4, exec_valid, prog_addr}, 18'h20000);
      @(posedge clk) rst_n <= 1'b1;
      first_cycle();
      // Straight-line code, one instruction per cycle
      for (int i = 0; i < 4; i++) begin
         sync1();
         check("instr", {exec_valid, instr}, {1'b1, rows[i].word});
         check("pc", prog_addr, i + 1);
         ph(1);
         check("rd", {dmem.rd, dmem.addr}, {1'b1, rows[i].word[7:0]});
         ph(2);
         check("operand", operand, rows[i].init);
         ph(3);
         check("prog_rd", prog_rd, 1'b1);
         check("wr", dmem.wr, rows[i].wr);
         if (rows[i].wr) check("wdata", dmem.wdata, rows[i].wdata);
      end
      // Branch: two cycles, prefetched word dropped
      sync1();
      check("branch", instr, 14'h3020);
      sync1();
      check("target", {exec_valid, prog_addr}, 14'h0020);
      for (int n = 1; n < 4; n++) begin
         ph(n);
         check("flush", {exec_valid, dmem.rd, dmem.wr}, 0);
      end
      sync1();
      check("target_run", {exec_valid, instr}, 15'h5033);
      @(posedge clk) int_req <= 1'b1;
      sync1();
      check("int_entry", {int_ack, prog_addr}, 14'h2004);
      @(posedge clk) int_req <= 1'b0;
      for (int n = 1; n < 4; n++) begin
         ph(n);
         check("int_flush", {exec_valid, dmem.wr}, 0);
      end
      check("dram33", mdl.dram[8'h33], 8'h33);
      check("dram34", mdl.dram[8'h34], 8'h34);
      check("dram44", mdl.dram[8'h44], 8'h44);
      // EEPROM through its pointer; upper pointer bits ignored
      ee(1'b1, 1'b0, 1'b0, 8'hff, 8'h00);
      ee(1'b0, 1'b0, 1'b1, 8'h00, 8'ha5);
      ee(1'b1, 1'b0, 1'b0, 8'h40, 8'h00);
      ee(1'b0, 1'b0, 1'b1, 8'h00, 8'h3c);
      ee(1'b1, 1'b0, 1'b0, 8'h3f, 8'h00);
      ee(1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
      check("ee_old_ptr", ee_rdata, 8'ha5);
      ee(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
      check("ee_low", ee_rdata, 8'h3c);
      // Pointer left high so that the clear must bring it back to zero
      ee(1'b1, 1'b0, 1'b0, 8'h3f, 8'h00);
      // Master clear mid-run, cycle clock off
      @(posedge clk);
      master_clear_n_n <= 1'b0;
      rc_mode <= 1'b0;
      repeat (3) step();
      check("clear", {p1, p2, p3, p4, exec_valid, prog_addr, instr}, 32'h80000000);
      check("clear_bus", {dmem, operand}, 0);
      @(posedge clk) master_clear_n_n <= 1'b1;
      first_cycle();
      ph(2);
      check("clk_out_off", clk_out, 1'b0);
      ee(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
      check("ee_kept", ee_rdata, 8'h3c);
      report_and_stop();
   end
endmodule
